/* File: mce_pkg.sv */
package mce_pkg;

  // Clock and long-silence timing
  localparam int unsigned     CLK_HZ           = 200_000_000;
  localparam int unsigned     COMM_TIMEOUT_H   = 6;
  localparam int unsigned     SEC_PER_H        = 3600;
  localparam longint unsigned COMM_TIMEOUT_CYC =
    longint'(COMM_TIMEOUT_H) * longint'(SEC_PER_H) * longint'(CLK_HZ);
  localparam int              CNT_W            = 48;

  // Event slots; code of a slot is EVT_BASE plus its index
  localparam logic [7:0] EVT_BASE = 8'h6e;
  localparam int         EV_LOST  = 0;
  localparam int         EV_OK    = 1;
  localparam int         EV_BATT  = 2;
  localparam int         EV_FRAUD = 3;
  localparam int         EV_CLOCK = 4;
  localparam int         EV_NEW   = 5;
  localparam int         EV_PERM  = 6;
  localparam int         EV_N     = 7;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_LAST  = 8'h08;
  localparam logic [7:0] REG_PEND  = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;

  // Control fields and reset values
  localparam int   CTRL_EN_BIT   = 0;
  localparam int   CTRL_BIND_BIT = 1;
  localparam logic CTRL_EN_RST   = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status word carried in each meter message
  typedef struct packed {
    logic [5:0] spare;
    logic       temp_sensor_fault;
    logic       calib_fault;
    logic       system_hardware_fault;
    logic       software_fault;
    logic       clock_sync_fault;
    logic       tamper_magnetic;
    logic       tamper_case;
    logic       tamper_pressure_port_zero;
    logic       tamper_pressure_port_two;
    logic       battery_low;
  } mce_stat_s;

  // One received message: valid is a one-cycle pulse
  typedef struct packed {
    logic      valid;
    mce_stat_s status;
  } mce_msg_s;

  typedef logic [7:0] mce_code_t;

endpackage

/* File: mce_ch2_monitor.sv */
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module mce_ch2_monitor #(
  parameter longint unsigned TIMEOUT_CYCLES = mce_pkg::COMM_TIMEOUT_CYC,
  parameter int              ADDR_W         = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Meter messages
  input  wire mce_pkg::mce_msg_s msg,
  // Event log hand-off
  output logic                   evt_valid,
  output mce_pkg::mce_code_t     evt_code,
  input  wire logic              evt_ready
);
  import mce_pkg::*;

  // Refuse sizes the logic cannot serve
  generate
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (64'd1 << CNT_W)) begin
      $error("TIMEOUT_CYCLES out of range");
    end
    if (ADDR_W < 5 || ADDR_W > 8) begin
      $error("ADDR_W must be 5 to 8");
    end
  endgenerate

  localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

  logic              en_reg;
  logic              lost_reg;
  logic              await_reg;
  logic              prev_ok_reg;
  mce_stat_s         prev_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [EV_N-1:0]   pend_reg;
  logic [EV_N-1:0]   pend_next;
  logic [31:0]       count_reg;
  logic              evt_valid_reg;
  mce_code_t         evt_code_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [7:0]        wa_reg;
  logic [31:0]       wd_reg;
  logic [3:0]        ws_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;

  // Bus write decode
  logic do_write;
  logic wr_ctrl;
  logic wr_mapped;
  logic bind_w;
  assign do_write  = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_ctrl   = do_write && (wa_reg == REG_CTRL) && ws_reg[0];
  assign wr_mapped = (wa_reg == REG_CTRL) || (wa_reg == REG_STATE) ||
                     (wa_reg == REG_LAST) || (wa_reg == REG_PEND) ||
                     (wa_reg == REG_COUNT);
  assign bind_w    = wr_ctrl && wd_reg[CTRL_BIND_BIT];

  // Message qualification and edge finding
  logic      msg_ok;
  logic      tmo_hit;
  mce_stat_s rise_w;
  assign msg_ok  = msg.valid && en_reg;
  assign tmo_hit = en_reg && !msg_ok && !lost_reg && (cnt_reg == TMO_LAST);
  assign rise_w  = (msg_ok && prev_ok_reg) ? (msg.status & ~prev_reg) : '0;

  // Event sources
  logic [EV_N-1:0] set_w;
  assign set_w[EV_LOST]  = tmo_hit;
  assign set_w[EV_OK]    = msg_ok && lost_reg;
  assign set_w[EV_BATT]  = rise_w.battery_low;
  assign set_w[EV_FRAUD] = rise_w.tamper_pressure_port_two ||
                           rise_w.tamper_pressure_port_zero ||
                           rise_w.tamper_case || rise_w.tamper_magnetic;
  assign set_w[EV_CLOCK] = rise_w.clock_sync_fault;
  assign set_w[EV_NEW]   = msg_ok && await_reg && !bind_w;
  assign set_w[EV_PERM]  = rise_w.software_fault ||
                           rise_w.system_hardware_fault ||
                           rise_w.calib_fault || rise_w.temp_sensor_fault;

  // Lowest pending slot goes out first
  logic [2:0] pick_idx;
  logic       pick_any;
  always_comb begin
    pick_idx = '0;
    pick_any = 1'b0;
    for (int i = EV_N - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pick_idx = 3'(i);
        pick_any = 1'b1;
      end
    end
  end

  // Output stage reloads when empty or drained; new sets beat the take
  logic            load_w;
  logic [EV_N-1:0] take_w;
  assign load_w    = !evt_valid_reg || evt_ready;
  assign take_w    = (load_w && pick_any) ? (EV_N'(1) << pick_idx) : '0;
  assign pend_next = (pend_reg & ~take_w) | set_w;

  // Silence counter; held at zero while lost so the loss fires once
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_reg || msg_ok || lost_reg || tmo_hit) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Link and binding state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lost_reg    <= 1'b0;
      await_reg   <= 1'b0;
      prev_ok_reg <= 1'b0;
      prev_reg    <= '0;
    end else begin
      if (tmo_hit) begin
        lost_reg <= 1'b1;
      end else if (msg_ok) begin
        lost_reg <= 1'b0;
      end
      if (msg_ok) begin
        prev_reg <= msg.status;
      end
      // New device starts with no history, so no stale edges
      if (bind_w) begin
        await_reg   <= 1'b1;
        prev_ok_reg <= 1'b0;
      end else if (msg_ok) begin
        await_reg   <= 1'b0;
        prev_ok_reg <= 1'b1;
      end
    end
  end

  // Pending events and event log hand-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg      <= '0;
      evt_valid_reg <= 1'b0;
      evt_code_reg  <= '0;
      count_reg     <= '0;
    end else begin
      pend_reg <= pend_next;
      if (load_w && pick_any) begin
        evt_valid_reg <= 1'b1;
        evt_code_reg  <= EVT_BASE + {5'h00, pick_idx};
      end else if (evt_ready) begin
        evt_valid_reg <= 1'b0;
      end
      if (evt_valid_reg && evt_ready) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= CTRL_EN_RST;
    end else if (wr_ctrl) begin
      en_reg <= wd_reg[CTRL_EN_BIT];
    end
  end

  // Write channels taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      wa_reg      <= '0;
      wd_reg      <= '0;
      ws_reg      <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        wa_reg      <= 8'(awaddr);
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        wd_reg     <= wdata;
        ws_reg     <= wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read decode; only aligned listed offsets answer OKAY
  logic [7:0]  ra_w;
  logic        rd_mapped;
  logic [31:0] rd_word;
  assign ra_w      = 8'(araddr);
  assign rd_mapped = (ra_w == REG_CTRL) || (ra_w == REG_STATE) ||
                     (ra_w == REG_LAST) || (ra_w == REG_PEND) ||
                     (ra_w == REG_COUNT);
  assign rd_word   =
    (ra_w == REG_CTRL)  ? {31'h0000_0000, en_reg} :
    (ra_w == REG_STATE) ? {29'h0000_0000, prev_ok_reg, await_reg,
                           lost_reg} :
    (ra_w == REG_LAST)  ? {16'h0000, prev_reg} :
    (ra_w == REG_PEND)  ? {25'h000_0000, pend_reg} :
    (ra_w == REG_COUNT) ? count_reg : 32'h0000_0000;

  // Read channel: one outstanding, answer the cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (arvalid && arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_word;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Port drive
  assign awready   = !aw_hold_reg;
  assign wready    = !w_hold_reg;
  assign bvalid    = bvalid_reg;
  assign bresp     = bresp_reg;
  assign arready   = !rvalid_reg;
  assign rvalid    = rvalid_reg;
  assign rresp     = rresp_reg;
  assign rdata     = rdata_reg;
  assign evt_valid = evt_valid_reg;
  assign evt_code  = evt_code_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_lost;
    tmo_hit |=> lost_reg && pend_reg[EV_LOST] && cnt_reg == '0;
  endproperty
  a_lost: assert property (p_lost) else $error("loss event missing");

  property p_restore;
    msg_ok && lost_reg |=> !lost_reg && pend_reg[EV_OK];
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore event missing");

  property p_batt;
    rise_w.battery_low |=> pend_reg[EV_BATT];
  endproperty
  a_batt: assert property (p_batt) else $error("battery event missing");

  property p_fraud;
    msg_ok && prev_ok_reg &&
    |(msg.status[4:1] & ~prev_reg[4:1]) |=> pend_reg[EV_FRAUD];
  endproperty
  a_fraud: assert property (p_fraud) else $error("fraud event missing");

  property p_clock;
    $rose(pend_reg[EV_CLOCK]) |-> $past(msg_ok) && $past(prev_ok_reg);
  endproperty
  a_clock: assert property (p_clock) else $error("clock event w/o msg");

  property p_new;
    msg_ok && await_reg && !bind_w |=> !await_reg && pend_reg[EV_NEW];
  endproperty
  a_new: assert property (p_new) else $error("new device missing");

  property p_perm;
    msg_ok && prev_ok_reg &&
    |(msg.status[9:6] & ~prev_reg[9:6]) |=> pend_reg[EV_PERM];
  endproperty
  a_perm: assert property (p_perm) else $error("fault event missing");

  property p_level;
    msg_ok && prev_ok_reg && prev_reg.battery_low &&
    !pend_reg[EV_BATT] |=> !pend_reg[EV_BATT];
  endproperty
  a_level: assert property (p_level) else $error("level retrigger");

  property p_hold;
    evt_valid && !evt_ready |=> evt_valid && $stable(evt_code) &&
      evt_code >= EVT_BASE && evt_code < EVT_BASE + 8'(EV_N);
  endproperty
  a_hold: assert property (p_hold) else $error("event not held");

  c_restore: cover property (evt_valid && evt_code == EVT_BASE + 8'(EV_OK));
  c_fraud: cover property (set_w[EV_FRAUD] ##[1:8] evt_valid);
  c_new: cover property (bind_w ##[1:20] set_w[EV_NEW]);
  c_b2b: cover property (evt_valid && evt_ready ##1 evt_valid);

endmodule

/* File: mce_meter_model.sv */
`timescale 1ns/1ps
// Channel-2 meter: sends one-cycle messages on request
module mce_meter_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench request
  input  wire logic        send,
  input  wire logic [15:0] stat,
  // Message to the monitor
  output mce_pkg::mce_msg_s msg
);
  import mce_pkg::*;
  // Between frames the status lines toggle so stale data never looks valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msg <= '0;
    end else begin
      msg.valid  <= send;
      msg.status <= send ? mce_stat_s'(stat) : mce_stat_s'(~msg.status);
    end
  end
endmodule

/* File: mce_ch2_monitor_tb.sv */
`timescale 1ns/1ps
module mce_ch2_monitor_tb;
  import mce_pkg::*;
  localparam longint unsigned TO = 60;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, evt_valid;
  logic        evt_ready, send;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, rr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] stat, prev, rise;
  logic [31:0] rq;
  logic        strb0;
  mce_code_t   evt_code;
  mce_msg_s    msg;
  int          bad_count, checks_done, handed, silent;
  int          en, bind_pend, have_prev, lost;
  int          exp_q[$];

  mce_ch2_monitor #(.TIMEOUT_CYCLES(TO), .ADDR_W(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .msg(msg),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_ready(evt_ready));
  mce_meter_model u_meter (
    .aclk(aclk), .aresetn(aresetn), .send(send), .stat(stat), .msg(msg));

  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    report_and_stop();
  endtask

  // Write both channels at once; response may be held off a few cycles
  // so that bvalid has to stand; waits are bounded
  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] want);
    int i;
    int dly;
    logic [31:0] r;
    r = xs();
    dly = int'(r[5:4]);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= {r[3:1], strb0};
    awvalid <= 1; wvalid <= 1; bready <= (dly == 0);
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1 && bready) break;
      if (i + 1 >= dly) bready <= 1;
    end
    bready <= 0;
    if (i == 50) hang();
    check("bresp", bresp, want);
    if (a == REG_CTRL && strb0) begin
      en = d[0];
      if (d[1]) bind_pend = 1;
    end
  endtask

  task automatic axi_rd(logic [7:0] a, logic [31:0] wd, logic [1:0] wr);
    int i;
    int dly;
    logic [31:0] r;
    r = xs();
    dly = int'(r[1:0]);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= (dly == 0);
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1 && rready) break;
      if (i + 1 >= dly) rready <= 1;
    end
    rready <= 0;
    if (i == 50) hang();
    check("rdata", rdata, wd);
    check("rresp", rresp, wr);
  endtask

  // Wait until every expected event has been handed off
  task automatic drain();
    int i;
    for (i = 0; i < 60 && (i < 3 || exp_q.size() != 0); i++) @(posedge aclk);
    if (exp_q.size() != 0) hang();
  endtask

  task automatic send_msg(logic [15:0] v);
    @(posedge aclk);
    send <= 1; stat <= v;
    @(posedge aclk);
    send <= 0;
    drain();
  endtask

  // Event log stalls at random
  always @(posedge aclk) begin
    rq = xs();
    evt_ready <= rq[0] | rq[1];
  end

  // Reference model: silence counter, status edges, bind, event order
  always @(posedge aclk) begin
    if (!aresetn) begin
      lost = 0; silent = 0; have_prev = 0; bind_pend = 0; en = 1;
      handed = 0;
    end else begin
      if (evt_valid === 1'b1 && evt_ready) begin
        check("evt_code", evt_code, exp_q.size() ? exp_q.pop_front() : 0);
        handed++;
      end
      if (msg.valid && en) begin
        silent = 0;
        if (lost) exp_q.push_back(111);
        lost = 0;
        rise = msg.status & ~prev;
        if (bind_pend) exp_q.push_back(115);
        else if (have_prev) begin
          if (rise[0]) exp_q.push_back(112);
          if (|rise[4:1]) exp_q.push_back(113);
          if (rise[5]) exp_q.push_back(114);
          if (|rise[9:6]) exp_q.push_back(116);
        end
        bind_pend = 0; have_prev = 1; prev = msg.status;
      end else if (!en) silent = 0;
      else if (!lost && ++silent == TO) begin
        lost = 1;
        exp_q.push_back(110);
      end
    end
  end

  initial begin
    seed = 32'hb2e5_e7b6; bad_count = 0; checks_done = 0; handed = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; send = 0; stat = 0;
    evt_ready = 0; prev = 0; aresetn = 0; strb0 = 1;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    axi_rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    axi_rd(8'h14, 32'h0000_0000, RESP_SLVERR);
    axi_wr(REG_STATE, 32'hffff_ffff, RESP_OKAY);
    // Lane 0 off: control write must not land
    strb0 = 0;
    axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    strb0 = 1;
    axi_rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    $display("test regs done");
    send_msg(16'h0000);
    for (int b = 0; b < 16; b++) begin
      rr = xs();
      send_msg(16'h0001 << b);
      send_msg((16'h0001 << b) | {rr[5:0], 10'h000});
      send_msg(16'h0000);
    end
    for (int k = 0; k < 8; k++) begin
      rr = xs();
      send_msg(rr[15:0]);
    end
    $display("test status done");
    axi_wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    send_msg(16'h03ff);
    axi_wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    send_msg(16'h0000);
    $display("test enable done");
    repeat (TO + 20) @(posedge aclk);
    drain();
    axi_rd(REG_STATE, 32'h0000_0005, RESP_OKAY);
    send_msg(16'h0020);
    $display("test loss done");
    axi_wr(REG_CTRL, 32'h0000_0003, RESP_OKAY);
    send_msg(16'h0041);
    send_msg(16'h0043);
    axi_rd(REG_LAST, {16'h0000, prev}, RESP_OKAY);
    axi_rd(REG_PEND, 32'h0000_0000, RESP_OKAY);
    axi_rd(REG_COUNT, handed, RESP_OKAY);
    $display("test bind done");
    // Mid-run reset drops link state, history and the event count
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    axi_rd(REG_STATE, 32'h0000_0000, RESP_OKAY);
    send_msg(16'h03ff);
    axi_rd(REG_LAST, 32'h0000_03ff, RESP_OKAY);
    axi_rd(REG_COUNT, handed, RESP_OKAY);
    $display("test reset done");
    report_and_stop();
  end
endmodule
